// *** itc_top.sv ***
// Control and status for eight isochronous transmit contexts.
// Assumes the descriptor engine and cycle timer share clk_in.
module itc_top (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire itc_pkg::itc_evt_t evt_in,
  input wire logic [4:0] code_in,
  input wire logic cyc_start_in,
  input wire itc_pkg::itc_cyc_t cyc_in,
  input wire logic fatal_bus_error_flag_in,
  output logic [31:0] rdata_out,
  output logic [7:0] run_out,
  output logic [7:0] xmit_en_out,
  output logic [7:0] overflow_out,
  output logic irq_out
);
  import itc_pkg::*;

  typedef enum logic [1:0] {
    ITC_IDLE = 2'b00,
    ITC_WAIT = 2'b01,
    ITC_BUSY = 2'b10
  } itc_phase_t;

  typedef struct packed {
    itc_ctx_t [ITC_NUM_CTX-1:0] ctx;
    itc_phase_t [ITC_NUM_CTX-1:0] phase;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [31:0] rdata;
    logic [7:0] xmit_en;
    logic [7:0] ovf;
    logic irq;
  } itc_state_t;

  itc_state_t s_r;
  itc_state_t s_nxt;
  logic [2:0] sel;
  logic hit_set;
  logic hit_clr;
  logic stat_rd;
  logic [31:0] ctx_view [ITC_NUM_CTX];

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    sel = addr_in[6:4];
    hit_set = (addr_in[11:7] == ITC_SET_BASE[11:7]) && (addr_in[3:0] == ITC_SET_BASE[3:0]); // R01
    hit_clr = (addr_in[11:7] == ITC_CLR_BASE[11:7]) && (addr_in[3:0] == ITC_CLR_BASE[3:0]); // R01
    stat_rd = rd_in && (addr_in == ITC_IRQ_STAT);
  end

  // ****************************************
  // Readback views
  // ****************************************
  // Image of each context; reserved and speed bits stay low
  always_comb begin
    for (int i = 0; i < ITC_NUM_CTX; i++) begin
      ctx_view[i] = 32'h0000_0000; // R12 R13
      ctx_view[i][ITC_ARM_BIT] = s_r.ctx[i].arm;
      ctx_view[i][ITC_MATCH_HI:ITC_MATCH_LO] = s_r.ctx[i].match;
      ctx_view[i][ITC_RUN_BIT] = s_r.ctx[i].run;
      ctx_view[i][ITC_WAKE_BIT] = s_r.ctx[i].wake;
      ctx_view[i][ITC_DEAD_BIT] = s_r.ctx[i].dead;
      ctx_view[i][ITC_ACTIVE_BIT] = s_r.ctx[i].active;
      ctx_view[i][ITC_CODE_HI:0] = s_r.ctx[i].code; // R14
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [7:0] ev;
    logic was_run;
    ev = 8'h00;
    was_run = 1'b0;
    s_nxt = s_r;
    for (int i = 0; i < ITC_NUM_CTX; i++) begin
      s_nxt.xmit_en[i] = 1'b0;
      was_run = s_r.ctx[i].run;
      // Software access
      if (wr_in && (hit_set || hit_clr) && sel == i[2:0]) begin
        if (hit_set) begin // R02
          s_nxt.ctx[i].arm = s_r.ctx[i].arm | wdata_in[ITC_ARM_BIT];
          s_nxt.ctx[i].match = s_r.ctx[i].match | wdata_in[ITC_MATCH_HI:ITC_MATCH_LO];
          s_nxt.ctx[i].run = s_r.ctx[i].run | wdata_in[ITC_RUN_BIT]; // R08
          s_nxt.ctx[i].wake = s_r.ctx[i].wake | wdata_in[ITC_WAKE_BIT]; // R09
        end else begin // R02
          s_nxt.ctx[i].arm = s_r.ctx[i].arm & ~wdata_in[ITC_ARM_BIT];
          s_nxt.ctx[i].match = s_r.ctx[i].match & ~wdata_in[ITC_MATCH_HI:ITC_MATCH_LO];
          s_nxt.ctx[i].run = s_r.ctx[i].run & ~wdata_in[ITC_RUN_BIT]; // R08
        end
      end
      // A fetch always drops wake, even beside a set write
      if (evt_in.fetch[i]) begin
        s_nxt.ctx[i].wake = 1'b0; // R09
      end
      // Clearing run stops the context and clears dead
      if (was_run && !s_nxt.ctx[i].run) begin
        s_nxt.ctx[i].dead = 1'b0; // R10
        s_nxt.ctx[i].active = 1'b0;
        s_nxt.ctx[i].skips = ITC_SKIP_RST;
        s_nxt.phase[i] = ITC_IDLE;
      end else begin
        if (evt_in.fatal[i]) begin
          s_nxt.ctx[i].dead = 1'b1; // R10
          ev[i] = 1'b1;
        end
        if (evt_in.last[i]) begin
          s_nxt.ctx[i].code = code_in; // R14
          ev[i] = 1'b1;
        end
        // Skipped cycles counted on overflow conditions
        if (evt_in.skip[i] && s_r.ctx[i].run && (s_r.ctx[i].dead ||
            s_r.ctx[i].code == ITC_EVT_TIMEOUT || fatal_bus_error_flag_in)) begin
          if (s_r.ctx[i].skips == ITC_MAX_SKIPS) begin
            s_nxt.ovf[i] = 1'b1; // R15
            ev[i] = 1'b1;
          end else begin
            s_nxt.ctx[i].skips = s_r.ctx[i].skips + 3'h1; // R15
          end
        end
        if (evt_in.start[i]) begin
          s_nxt.ctx[i].skips = ITC_SKIP_RST;
        end
        // Context sequencing
        case (s_r.phase[i])
          ITC_IDLE: begin
            if (s_r.ctx[i].run && !s_r.ctx[i].dead && evt_in.start[i]) begin
              s_nxt.ctx[i].active = 1'b1; // R11
              s_nxt.phase[i] = s_r.ctx[i].arm ? ITC_WAIT : ITC_BUSY; // R07
              s_nxt.ctx[i].arm = 1'b0; // R06
            end
          end
          ITC_WAIT: begin
            // Only the cycle start strobed now is compared
            if (cyc_start_in && cyc_in == s_r.ctx[i].match) begin // R03 R04 R05
              s_nxt.phase[i] = ITC_BUSY;
            end
          end
          ITC_BUSY: begin
            if (evt_in.done[i] || evt_in.fatal[i]) begin
              s_nxt.ctx[i].active = 1'b0; // R11
              s_nxt.phase[i] = ITC_IDLE;
            end
          end
          default: begin
            s_nxt.phase[i] = ITC_IDLE;
          end
        endcase
        if (s_r.phase[i] == ITC_WAIT && cyc_start_in && cyc_in == s_r.ctx[i].match) begin
          s_nxt.xmit_en[i] = 1'b1; // R03
        end else if (s_r.phase[i] == ITC_BUSY) begin
          s_nxt.xmit_en[i] = ~evt_in.done[i] & ~evt_in.fatal[i];
        end
      end
    end
    // Interrupt status, set wins over read clear
    s_nxt.stat = (stat_rd ? 8'h00 : s_r.stat) | ev;
    if (wr_in && addr_in == ITC_IRQ_MASK) begin
      s_nxt.mask = wdata_in[7:0];
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // Read data, one cycle later
    s_nxt.rdata = 32'h0000_0000;
    if (rd_in) begin
      if (hit_set || hit_clr) begin
        // Either view returns the same image
        s_nxt.rdata = ctx_view[sel]; // R02
      end else if (addr_in == ITC_IRQ_STAT) begin
        s_nxt.rdata[7:0] = s_r.stat;
      end else if (addr_in == ITC_IRQ_MASK) begin
        s_nxt.rdata[7:0] = s_r.mask;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_r <= '0; // R16
    end else if (ce_in) begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  always_comb begin
    rdata_out = s_r.rdata;
    xmit_en_out = s_r.xmit_en;
    overflow_out = s_r.ovf;
    irq_out = s_r.irq;
    for (int i = 0; i < ITC_NUM_CTX; i++) begin
      run_out[i] = s_r.ctx[i].run;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_reset_clears: assert property (@(posedge clk_in) $past(rst_in) |-> run_out == 8'h00) // R16
    else $error("run not zero after reset");
  a_run_set_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && wr_in && hit_set && sel == 3'h0 && wdata_in[15] |=> s_r.ctx[0].run) // R08
    else $error("run not set by write");
  a_run_sw_only: assert property (@(posedge clk_in) disable iff (rst_in)
    !(ce_in && wr_in && (hit_set || hit_clr)) |=> $stable(run_out)) // R08
    else $error("run changed without write");
  a_dead_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && s_r.ctx[0].run && !s_nxt.ctx[0].run |=> !s_r.ctx[0].dead) // R10
    else $error("dead not cleared");
  a_wake_fetch: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && evt_in.fetch[1] && !(wr_in && hit_set) |=> !s_r.ctx[1].wake) // R09
    else $error("wake not cleared on fetch");
  a_arm_cleared: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(s_r.ctx[0].active) |-> !s_r.ctx[0].arm) // R06
    else $error("arm still set when active");
  a_reserved_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    rdata_out[14:13] == 2'b00 && rdata_out[9:5] == 5'h00) // R12
    else $error("reserved bits nonzero");
  a_code_write: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && evt_in.last[2] && s_r.ctx[2].run && s_nxt.ctx[2].run |=> s_r.ctx[2].code == $past(code_in)) // R14
    else $error("completion code not written");
  a_match_enable: assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && s_r.phase[0] == ITC_WAIT && cyc_start_in && cyc_in == s_r.ctx[0].match
    && s_nxt.ctx[0].run |=> xmit_en_out[0]) // R03
    else $error("match did not enable transmit");
  a_irq_level: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_out == |(s_r.stat & s_r.mask))
    else $error("irq not tied to status");

  // Wake follows a set write unless a fetch lands with it
  a_wake_set_write: assert property (@(posedge clk_in) disable iff (rst_in) // R09
    ce_in && wr_in && hit_set && sel == 3'h0 && wdata_in[ITC_WAKE_BIT] && !evt_in.fetch[0]
    |=> s_r.ctx[0].wake)
    else $error("wake not set by write");

  // A fetch beats any write to wake
  a_wake_fetch_wins: assert property (@(posedge clk_in) disable iff (rst_in) // R09
    ce_in && evt_in.fetch[0] |=> !s_r.ctx[0].wake)
    else $error("wake kept over fetch");

  // Fatal error marks the context dead
  a_dead_on_fatal: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    ce_in && evt_in.fatal[0] && !(s_r.ctx[0].run && !s_nxt.ctx[0].run)
    |=> s_r.ctx[0].dead)
    else $error("dead not set on fatal");

  // A dead context never starts again
  a_dead_blocks_start: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    ce_in && s_r.ctx[0].dead && s_r.phase[0] == ITC_IDLE |=> s_r.phase[0] == ITC_IDLE)
    else $error("dead context started");

  // Start of processing raises active
  a_active_on_start: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    ce_in && s_r.phase[0] == ITC_IDLE && s_r.ctx[0].run && !s_r.ctx[0].dead
    && evt_in.start[0] && s_nxt.ctx[0].run |=> s_r.ctx[0].active)
    else $error("active not set on start");

  // End of processing drops active
  a_active_on_done: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    ce_in && s_r.phase[0] == ITC_BUSY && evt_in.done[0] |=> !s_r.ctx[0].active)
    else $error("active kept after done");

  // Active mirrors a phase other than idle
  a_phase_active: assert property (@(posedge clk_in) disable iff (rst_in) // R11
    s_r.ctx[0].active == (s_r.phase[0] != ITC_IDLE))
    else $error("active and phase disagree");

  // Clear view drops arm
  a_clear_view_arm: assert property (@(posedge clk_in) disable iff (rst_in) // R02
    ce_in && wr_in && hit_clr && sel == 3'h2 && wdata_in[ITC_ARM_BIT]
    |=> !s_r.ctx[2].arm)
    else $error("arm not cleared by write");

  // Zeros written leave the match field alone
  a_zero_write_keeps: assert property (@(posedge clk_in) disable iff (rst_in) // R02
    ce_in && wr_in && (hit_set || hit_clr) && sel == 3'h2 && wdata_in == 32'h0
    |=> $stable(s_r.ctx[2].match))
    else $error("zero write changed match");

  // No transmit while waiting for a different cycle
  a_match_waits: assert property (@(posedge clk_in) disable iff (rst_in) // R05
    ce_in && s_r.phase[0] == ITC_WAIT && !(cyc_start_in && cyc_in == s_r.ctx[0].match)
    |=> !xmit_en_out[0])
    else $error("transmit before match");

  // Idle contexts never enable transmit
  a_no_early_xmit: assert property (@(posedge clk_in) disable iff (rst_in) // R07
    ce_in && s_r.phase[0] == ITC_IDLE |=> !xmit_en_out[0])
    else $error("transmit while idle");

  // Overflow flag stays until reset
  a_ovf_sticky: assert property (@(posedge clk_in) disable iff (rst_in) // R15
    overflow_out[1] |=> overflow_out[1])
    else $error("overflow flag dropped");

  // Eighth counted skip raises overflow
  a_skip_limit: assert property (@(posedge clk_in) disable iff (rst_in) // R15
    ce_in && s_r.ctx[1].skips == ITC_MAX_SKIPS && evt_in.skip[1] && s_r.ctx[1].run
    && s_nxt.ctx[1].run && fatal_bus_error_flag_in |=> overflow_out[1])
    else $error("overflow not raised");

  // Completion code only moves on a last-output event
  a_code_hold: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    ce_in && !evt_in.last[2] |=> $stable(s_r.ctx[2].code))
    else $error("code changed without event");

  // Clock enable low freezes all state
  a_frozen: assert property (@(posedge clk_in) disable iff (rst_in) // R08
    !ce_in |=> $stable(s_r))
    else $error("state moved while frozen");

  // Reset leaves status bits clear
  a_reset_state: assert property (@(posedge clk_in) // R16
    $past(rst_in) |-> !s_r.ctx[0].dead && !s_r.ctx[0].active && overflow_out == 8'h00)
    else $error("status not clear after reset");

  // Read data stands only after a read
  a_rdata_idle: assert property (@(posedge clk_in) disable iff (rst_in) // R02
    ce_in && !rd_in |=> rdata_out == 32'h0)
    else $error("read data without read");

  // Clear view stops the context
  a_run_clear_write: assert property (@(posedge clk_in) disable iff (rst_in) // R08
    ce_in && wr_in && hit_clr && sel == 3'h0 && wdata_in[ITC_RUN_BIT] |=> !s_r.ctx[0].run)
    else $error("run not cleared by write");

  // Set view arms the cycle match
  a_arm_set_write: assert property (@(posedge clk_in) disable iff (rst_in) // R03
    ce_in && wr_in && hit_set && sel == 3'h2 && wdata_in[ITC_ARM_BIT] && !evt_in.start[2]
    |=> s_r.ctx[2].arm)
    else $error("arm not set by write");

  // Set view loads all ones into the match field
  a_match_set_write: assert property (@(posedge clk_in) disable iff (rst_in) // R04
    ce_in && wr_in && hit_set && sel == 3'h2
    && wdata_in[ITC_MATCH_HI:ITC_MATCH_LO] == 15'h7fff |=> s_r.ctx[2].match == 15'h7fff)
    else $error("match not set by write");

  // Run holds without a clear write
  a_run_holds: assert property (@(posedge clk_in) disable iff (rst_in) // R08
    ce_in && s_r.ctx[1].run && !(wr_in && hit_clr && sel == 3'h1) |=> s_r.ctx[1].run)
    else $error("run dropped by hardware");

  // Dead holds while run stays set
  a_dead_holds: assert property (@(posedge clk_in) disable iff (rst_in) // R10
    ce_in && s_r.ctx[0].dead && s_nxt.ctx[0].run |=> s_r.ctx[0].dead)
    else $error("dead dropped while running");

  // Busy context keeps transmit enabled
  a_xmit_after_start: assert property (@(posedge clk_in) disable iff (rst_in) // R07
    ce_in && s_r.phase[3] == ITC_BUSY && !evt_in.done[3] && !evt_in.fatal[3]
    && s_nxt.ctx[3].run |=> xmit_en_out[3])
    else $error("busy context not enabled");

  // Stopped contexts count no skips
  a_skips_idle: assert property (@(posedge clk_in) disable iff (rst_in) // R15
    ce_in && !s_r.ctx[1].run |=> s_r.ctx[1].skips == ITC_SKIP_RST)
    else $error("skips counted while stopped");

  // Last-output event raises status
  a_stat_on_last: assert property (@(posedge clk_in) disable iff (rst_in) // R14
    ce_in && evt_in.last[0] && !(s_r.ctx[0].run && !s_nxt.ctx[0].run) |=> s_r.stat[0])
    else $error("status not set on last");

  // Unarmed and matched start, a full skip count, a dead context and overflow
  c_plain_start: cover property (@(posedge clk_in) xmit_en_out[3]);
  c_skip_full: cover property (@(posedge clk_in) s_r.ctx[1].skips == ITC_MAX_SKIPS);
  c_match_start: cover property (@(posedge clk_in) xmit_en_out[0] && s_r.phase[0] == ITC_BUSY);
  c_dead: cover property (@(posedge clk_in) s_r.ctx[0].dead);
  c_overflow: cover property (@(posedge clk_in) overflow_out != 8'h00);
endmodule

// *** itc_pkg.sv ***
// Package for the isochronous transmit context control block.
// Assumes a single 20 MHz clock and a plain strobe register port.
//
// Operation
// R01: Eight transmit contexts, set view at 200h plus 16 per context, clear view at 204h plus 16.
// R02: Ones written to the set view set bits, ones to the clear view clear them, zeros change nothing.
// R03: With cycle_match_arm set, the first packet goes out in the cycle equal to target_cycle_value.
// R04: target_cycle_value is bits 30..16, compared with two seconds bits and the 13-bit cycle number.
// R05: The comparison uses the cycle start seen just before transmission begins.
// R06: Hardware clears cycle_match_arm once the context has become active.
// R07: Descriptor processing may start ahead of the matched cycle.
// R08: Software sets and clears run; hardware changes run only on reset.
// R09: Software sets wake; hardware clears it on every descriptor fetch.
// R10: dead is set on a fatal error and cleared when software clears run.
// R11: active is one while the context processes descriptors.
// R12: Reserved bits 14..13 and 9..8 read as zero.
// R13: Bits 7..5 carry no meaning for transmit and are not kept.
// R14: After each last-output command the completion code in bits 4..0 is written.
// R15: On overflow each running context tolerates up to seven skipped cycles.
// R16: At reset run, dead, active and the reserved bits are zero.
package itc_pkg;
  // ****************************************
  // Address map
  // ****************************************
  localparam logic [11:0] ITC_SET_BASE = 12'h200;
  localparam logic [11:0] ITC_CLR_BASE = 12'h204;
  localparam logic [11:0] ITC_CTX_STRIDE = 12'h010;
  localparam logic [11:0] ITC_IRQ_STAT = 12'h300;
  localparam logic [11:0] ITC_IRQ_MASK = 12'h304;
  localparam int ITC_NUM_CTX = 8;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ITC_ARM_BIT = 31;
  localparam int ITC_MATCH_HI = 30;
  localparam int ITC_MATCH_LO = 16;
  localparam int ITC_RUN_BIT = 15;
  localparam int ITC_WAKE_BIT = 12;
  localparam int ITC_DEAD_BIT = 11;
  localparam int ITC_ACTIVE_BIT = 10;
  localparam int ITC_CODE_HI = 4;
  localparam logic [2:0] ITC_MAX_SKIPS = 3'h7;
  // Completion codes
  localparam logic [4:0] ITC_EVT_TIMEOUT = 5'h0a;
  // Reset values
  localparam logic [14:0] ITC_MATCH_RST = 15'h0000;
  localparam logic [4:0] ITC_CODE_RST = 5'h00;
  localparam logic [2:0] ITC_SKIP_RST = 3'h0;
  // Timing: clock 20 MHz, period in ns
  localparam int ITC_CLK_NS = 50;

  // Per-context state
  typedef struct packed {
    logic arm;
    logic [14:0] match;
    logic run;
    logic wake;
    logic dead;
    logic active;
    logic [4:0] code;
    logic [2:0] skips;
  } itc_ctx_t;

  // Hardware events from the descriptor engine, one bit per context
  typedef struct packed {
    logic [7:0] start;
    logic [7:0] fetch;
    logic [7:0] fatal;
    logic [7:0] done;
    logic [7:0] last;
    logic [7:0] skip;
  } itc_evt_t;

  // Cycle timer snapshot
  typedef struct packed {
    logic [1:0] seconds_count_field;
    logic [12:0] cycle_number_field;
  } itc_cyc_t;
endpackage

// *** tb_top.sv ***
// Self-checking bench for the transmit context control block.
// Assumes one 20 MHz clock and the strobe register port of itc_top.
// ****************************************
// Bench
// ****************************************
module tb_top;
  import itc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] wa;
    logic [31:0] wd;
    logic [11:0] ra;
    logic [31:0] ex;
  } itc_row_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ce_in = 1'b1;
  logic [11:0] addr_in = 12'h000;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  itc_evt_t evt_in = '0;
  logic [4:0] code_in = 5'h00;
  logic cyc_start_in = 1'b0;
  itc_cyc_t cyc_in = '0;
  logic fatal_bus_error_flag_in = 1'b0;
  logic [31:0] rdata_out;
  logic [7:0] run_out, xmit_en_out, overflow_out;
  logic irq_out;
  int mismatches = 0;
  int samples_checked = 0;
  itc_row_t rows [4];
  itc_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .evt_in(evt_in), .code_in(code_in),
    .cyc_start_in(cyc_start_in), .cyc_in(cyc_in),
    .fatal_bus_error_flag_in(fatal_bus_error_flag_in), .rdata_out(rdata_out),
    .run_out(run_out), .xmit_en_out(xmit_en_out), .overflow_out(overflow_out),
    .irq_out(irq_out));
  // Clock at 50 ns
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // Compare and count
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // One-cycle register write
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  // Read, data checked in the following cycle
  task rd(input logic [11:0] a, input logic [31:0] ex);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk("rdata", rdata_out, ex);
  endtask
  // One-cycle engine event
  task ev(input itc_evt_t e);
    @(posedge clk_in);
    evt_in <= e;
    @(posedge clk_in);
    evt_in <= '0;
  endtask
  task cyc(input logic [14:0] v);
    @(posedge clk_in);
    cyc_in <= v;
    cyc_start_in <= 1'b1;
    @(posedge clk_in);
    cyc_start_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
  // Main sequence
  initial begin
    itc_evt_t e;
    rows[0] = {12'h220, 32'hffff_efff, 12'h224, 32'hffff_8000};
    rows[1] = {12'h224, 32'h8000_0000, 12'h220, 32'h7fff_8000};
    rows[2] = {12'h220, 32'h0000_0000, 12'h224, 32'h7fff_8000};
    rows[3] = {12'h3f0, 32'hffff_ffff, 12'h3f0, 32'h0000_0000};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int n = 0; n < ITC_NUM_CTX; n++) begin
      rd(ITC_SET_BASE + 12'(n * 16), 32'h0);
      rd(ITC_CLR_BASE + 12'(n * 16), 32'h0);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      rd(rows[i].ra, rows[i].ex);
    end
    wr(12'h224, 32'h7fff_8000);
    $display("test table done");
    // Armed start waits for the matching cycle
    wr(12'h200, 32'h8105_8000);
    e = '0;
    e.start = 8'h01;
    ev(e);
    rd(12'h200, 32'h0105_8400);
    cyc(15'h0104);
    chk("xmit", 32'(xmit_en_out), 32'h0);
    cyc(15'h0105);
    chk("xmit", 32'(xmit_en_out), 32'h1);
    $display("test match done");
    // Wake cleared by a fetch
    wr(12'h200, 32'h0000_1000);
    rd(12'h204, 32'h0105_9400);
    e = '0;
    e.fetch = 8'h01;
    ev(e);
    rd(12'h204, 32'h0105_8400);
    // Completion code and interrupt
    wr(ITC_IRQ_MASK, 32'h1);
    code_in <= 5'h11;
    e = '0;
    e.last = 8'h01;
    ev(e);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'(irq_out), 32'h1);
    rd(12'h200, 32'h0105_8411);
    rd(ITC_IRQ_STAT, 32'h1);
    repeat (2) @(posedge clk_in);
    chk("irq", 32'(irq_out), 32'h0);
    $display("test code done");
    // Fatal error, then software stops the context
    e = '0;
    e.fatal = 8'h01;
    ev(e);
    rd(12'h200, 32'h0105_8811);
    chk("run", 32'(run_out), 32'h1);
    wr(12'h204, 32'h0000_8000);
    rd(12'h200, 32'h0105_0011);
    chk("run", 32'(run_out), 32'h0);
    $display("test fatal done");
    // Skipped cycles under the fatal flag
    wr(12'h210, 32'h0000_8000);
    fatal_bus_error_flag_in <= 1'b1;
    e = '0;
    e.skip = 8'h02;
    repeat (ITC_MAX_SKIPS) ev(e);
    @(posedge clk_in);
    chk("ovf", 32'(overflow_out), 32'h0);
    ev(e);
    repeat (2) @(posedge clk_in);
    chk("ovf", 32'(overflow_out), 32'h2);
    $display("test overflow done");
    // Unarmed start transmits at once, done ends it
    wr(12'h230, 32'h0000_8000);
    e = '0;
    e.start = 8'h08;
    ev(e);
    repeat (2) @(posedge clk_in);
    #1 chk("xmit", 32'(xmit_en_out), 32'h8);
    rd(12'h230, 32'h0000_8400);
    e = '0;
    e.done = 8'h08;
    ev(e);
    repeat (2) @(posedge clk_in);
    #1 chk("xmit", 32'(xmit_en_out), 32'h0);
    rd(12'h230, 32'h0000_8000);
    $display("test plain start done");
    // Clock enable low drops a write
    ce_in <= 1'b0;
    wr(12'h240, 32'h0000_8000);
    ce_in <= 1'b1;
    rd(12'h240, 32'h0);
    $display("test freeze done");
    // Reset in mid-run clears run and overflow
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    #1 chk("run", 32'(run_out), 32'h0);
    chk("ovf", 32'(overflow_out), 32'h0);
    rd(12'h210, 32'h0);
    $display("test reset again done");
    give_verdict();
  end
endmodule
